// ==== sfi_consts.svh ====
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the serial unit design, checker and bench files
`ifndef SFI_CONSTS_SVH
`define SFI_CONSTS_SVH
`define SFI_ADDR_W 3
`define SFI_OFS_MODE 3'h0
`define SFI_OFS_CTRL 3'h1
`define SFI_OFS_STAT 3'h2
`define SFI_OFS_TXB 3'h3
`define SFI_OFS_RXB 3'h4
`define SFI_OFS_PORT 3'h5
`define SFI_OFS_BAUD 3'h6
// Mode register fields
`define SFI_MODE_SYNC 0
// Control register fields
`define SFI_CTRL_CKLO 0
`define SFI_CTRL_CKHI 1
`define SFI_CTRL_TX_END_IRQ_ENABLE 2
`define SFI_CTRL_RXEN 4
`define SFI_CTRL_TXEN 5
`define SFI_CTRL_RIE 6
`define SFI_CTRL_TIE 7
// Status register fields
`define SFI_ST_TX_END_FLAG 2
`define SFI_ST_PER 3
`define SFI_ST_FER 4
`define SFI_ST_OVR 5
`define SFI_ST_RX_FULL_FLAG 6
`define SFI_ST_TX_EMPTY_FLAG 7
// Port fields
`define SFI_PORT_DATA 0
`define SFI_PORT_DIR 1
// Reset values
`define SFI_STAT_RST 8'h84
`define SFI_BAUD_RST 8'h05
// Timing
`define SFI_OVERSAMPLE 5'h10
`define SFI_SAMPLE_AT 4'h7
`define SFI_BITS 4'h8
`endif

// ==== sfi_pkg.sv ====
// Types of the serial flag and interrupt block
// Assumes sfi_consts.svh sits in the same folder
package sfi_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sfi_tx_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sfi_rx_t;
endpackage : sfi_pkg

// ==== sfi_serial_unit.sv ====
// Serial unit: status flags, interrupt request, error handling, tx/rx
// Assumes an Avalon-MM master on sys_clk and a remote partner on pins
//
// Functional notes
// - All four causes share one interrupt request output.
// - Transmit-empty request when empty flag and tx interrupt enable bit set.
// - Transmit-end request when end flag and end enable bit set.
// - Receive-full request when full flag and rx interrupt enable bit set.
// - Error request when any error flag set, gated by rx interrupt enable bit.
// - Empty and end flags are 1 after reset.
// - Buffer write clears empty flag; move to shifter sets it.
// - Buffer writes always accepted; unsent byte is overwritten.
// - Overrun sets overrun flag, keeps full flag, drops data.
// - Framing/parity errors without overrun still store the byte.
// - Buffer read clears full flag even after an overrun.
// - Frame end: full flag 0 completes, 1 flags overrun.
// - Every receive buffer read clears the full flag.
// - Receiver keeps running in break, framing error sets again.
// - Clearing tx enable resets transmitter; port bits drive pin.
// - Synchronous mode: no transmit start while an error flag is set.
// - Clearing rx enable leaves error flags untouched.
// - Async receive at 16x rate, sample on eighth base clock.
// - Clock pin pulses low one cycle when handed to port, unless sync mode has the external clock selected.
// - Sync mode: data pin pulses high one cycle when handed to port.
// - Empty flag 1 at last bit: set end flag; async holds mark level, sync holds last data bit.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`include "sfi_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sfi_serial_unit (
    // Clock and reset
    input wire logic sysClk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [`SFI_ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [7:0] avsWritedata,
    output logic [7:0] avsReaddata,
    output logic avsWaitrequest,
    // Serial pins
    input wire logic rxdPin,
    output logic txdOut,
    output logic txdOe,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    // Shared interrupt
    output logic irq
);
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [7:0] txBuf;
        logic [7:0] rxBuf;
        logic [1:0] port;
        logic [7:0] baud;
        logic [7:0] divCnt;
        logic ack;
        logic [7:0] rdata;
        sfi_pkg::sfi_tx_t txSt;
        logic [7:0] txShift;
        logic [3:0] txOs;
        logic [3:0] txBit;
        logic txd;
        logic sck;
        sfi_pkg::sfi_rx_t rxSt;
        logic [7:0] rxShift;
        logic [3:0] rxOs;
        logic [3:0] rxBit;
        logic par;
        logic [2:0] rxSync;
        logic rxd;
        logic [2:0] ckSync;
        logic ckLast;
        logic txWasSer;
        logic ckWasSer;
        logic txGlitch;
        logic ckGlitch;
        logic irq;
    } sfi_state_t;

    sfi_state_t q;
    sfi_state_t d;

    function automatic logic sfiParity(input logic [7:0] v);
        sfiParity = ^v;
    endfunction : sfiParity

    logic syncMode;
    logic txEn;
    logic rxEn;
    logic clkOutSel;
    logic tick;
    logic baseEn;
    logic wrHit;
    logic rdHit;
    logic txAcc;
    logic rxAcc;
    logic ckFall;
    logic ckRise;

    always_comb begin
        syncMode = q.mode[`SFI_MODE_SYNC];
        txEn = q.ctrl[`SFI_CTRL_TXEN];
        rxEn = q.ctrl[`SFI_CTRL_RXEN];
        clkOutSel = syncMode && !q.ctrl[`SFI_CTRL_CKHI];
        // Base clock: 16x bit rate in async, twice bit rate in sync
        tick = (q.divCnt == q.baud);
        // Writes land only at the edge where waitrequest is low
        wrHit = avsWrite && q.ack;
        rdHit = avsRead && !q.ack;
        ckFall = q.ckLast && !q.ckSync[2] && (q.ckSync[1] == q.ckSync[2]);
        ckRise = !q.ckLast && q.ckSync[2] && (q.ckSync[1] == q.ckSync[2]);
        d = q;
        d.irq = 1'b0;
        // Three-stage pin sync, change counts when last two agree
        d.rxSync = {q.rxSync[1:0], rxdPin};
        if (q.rxSync[1] == q.rxSync[2]) begin
            d.rxd = q.rxSync[2];
        end
        d.ckSync = {q.ckSync[1:0], sckIn};
        if (q.ckSync[1] == q.ckSync[2]) begin
            d.ckLast = q.ckSync[2];
        end
        d.divCnt = tick ? 8'h00 : q.divCnt + 8'h01;
        // Sync external clock edges drive shifting; internal uses tick
        baseEn = clkOutSel ? tick : (syncMode ? 1'b0 : tick);
        txAcc = 1'b0;
        rxAcc = 1'b0;

        // Bus side, one wait cycle then acknowledge
        d.ack = (avsRead || avsWrite) && !q.ack;
        if (wrHit) begin
            case (avsAddress)
                `SFI_OFS_MODE: d.mode = avsWritedata;
                `SFI_OFS_CTRL: d.ctrl = avsWritedata;
                `SFI_OFS_STAT: begin
                    // Flags clear by writing 0; error flags only here
                    d.stat[`SFI_ST_OVR] = q.stat[`SFI_ST_OVR] && avsWritedata[`SFI_ST_OVR];
                    d.stat[`SFI_ST_FER] = q.stat[`SFI_ST_FER] && avsWritedata[`SFI_ST_FER];
                    d.stat[`SFI_ST_PER] = q.stat[`SFI_ST_PER] && avsWritedata[`SFI_ST_PER];
                end
                `SFI_OFS_TXB: begin
                    d.txBuf = avsWritedata;
                    d.stat[`SFI_ST_TX_EMPTY_FLAG] = 1'b0;
                    d.stat[`SFI_ST_TX_END_FLAG] = 1'b0;
                end
                `SFI_OFS_PORT: d.port = avsWritedata[1:0];
                `SFI_OFS_BAUD: d.baud = avsWritedata;
                default: ;
            endcase
        end
        d.rdata = 8'h00;
        if (rdHit) begin
            case (avsAddress)
                `SFI_OFS_MODE: d.rdata = q.mode;
                `SFI_OFS_CTRL: d.rdata = q.ctrl;
                `SFI_OFS_STAT: d.rdata = q.stat;
                `SFI_OFS_TXB: d.rdata = q.txBuf;
                `SFI_OFS_RXB: begin
                    d.rdata = q.rxBuf;
                    d.stat[`SFI_ST_RX_FULL_FLAG] = 1'b0;
                end
                `SFI_OFS_PORT: d.rdata = {6'h00, q.port};
                `SFI_OFS_BAUD: d.rdata = q.baud;
                default: d.rdata = 8'h00;
            endcase
        end

        // Transmitter
        if (!txEn) begin
            d.txSt = sfi_pkg::TX_IDLE;
            d.txd = 1'b1;
            d.txOs = 4'h0;
        end else begin
            case (q.txSt)
                sfi_pkg::TX_IDLE: begin
                    if (!q.stat[`SFI_ST_TX_EMPTY_FLAG] && !(syncMode &&
                        (q.stat[`SFI_ST_OVR] || q.stat[`SFI_ST_FER] ||
                         q.stat[`SFI_ST_PER]))) begin
                        txAcc = 1'b1;
                        d.txSt = syncMode ? sfi_pkg::TX_DATA : sfi_pkg::TX_START;
                        d.txBit = 4'h0;
                        d.txOs = 4'h0;
                        if (syncMode) begin
                            d.txd = q.txBuf[0];
                        end else begin
                            d.txd = 1'b0;
                        end
                    end
                end
                sfi_pkg::TX_START: begin
                    d.txd = 1'b0;
                    if (baseEn) begin
                        d.txOs = q.txOs + 4'h1;
                        if (q.txOs == 4'hF) begin
                            d.txSt = sfi_pkg::TX_DATA;
                            d.txd = q.txShift[0];
                        end
                    end
                end
                sfi_pkg::TX_DATA: begin
                    if (syncMode) begin
                        // Data changes on falling clock, sampled on rising
                        if (clkOutSel ? (tick && q.sck) : ckFall) begin
                            d.txShift = {1'b1, q.txShift[7:1]};
                            d.txBit = q.txBit + 4'h1;
                            d.txd = q.txShift[1];
                            if (q.txBit == `SFI_BITS - 4'h1) begin
                                d.txSt = sfi_pkg::TX_STOP;
                                d.txd = q.txShift[0];
                            end
                        end
                    end else if (baseEn) begin
                        d.txOs = q.txOs + 4'h1;
                        if (q.txOs == 4'hF) begin
                            d.txShift = {1'b1, q.txShift[7:1]};
                            d.txBit = q.txBit + 4'h1;
                            d.txd = q.txShift[1];
                            if (q.txBit == `SFI_BITS - 4'h1) begin
                                d.txSt = sfi_pkg::TX_STOP;
                                d.txd = 1'b1;
                            end
                        end
                    end
                end
                sfi_pkg::TX_STOP: begin
                    if (syncMode || (baseEn && q.txOs == 4'hF)) begin
                        if (!q.stat[`SFI_ST_TX_EMPTY_FLAG]) begin
                            d.txSt = sfi_pkg::TX_IDLE;
                        end else begin
                            d.txSt = sfi_pkg::TX_IDLE;
                            d.stat[`SFI_ST_TX_END_FLAG] = 1'b1;
                        end
                    end else if (baseEn) begin
                        d.txOs = q.txOs + 4'h1;
                    end
                end
                default: d.txSt = sfi_pkg::TX_IDLE;
            endcase
        end
        if (txAcc) begin
            d.txShift = q.txBuf;
            d.stat[`SFI_ST_TX_EMPTY_FLAG] = 1'b1;
        end
        // Internal clock output toggles only while shifting
        if (clkOutSel && q.txSt == sfi_pkg::TX_DATA && tick) begin
            d.sck = !q.sck;
        end else if (q.txSt != sfi_pkg::TX_DATA) begin
            d.sck = 1'b1;
        end

        // Receiver keeps running through a break
        if (!rxEn) begin
            d.rxSt = sfi_pkg::RX_IDLE;
        end else begin
            case (q.rxSt)
                sfi_pkg::RX_IDLE: begin
                    d.rxOs = 4'h0;
                    d.rxBit = 4'h0;
                    d.par = 1'b0;
                    if (syncMode ? (clkOutSel ? q.txSt == sfi_pkg::TX_DATA : 1'b1)
                        : !q.rxd) begin
                        d.rxSt = syncMode ? sfi_pkg::RX_DATA : sfi_pkg::RX_START;
                    end
                end
                sfi_pkg::RX_START: begin
                    if (baseEn) begin
                        d.rxOs = q.rxOs + 4'h1;
                        if (q.rxOs == `SFI_SAMPLE_AT) begin
                            // False start rejected at mid-bit
                            d.rxSt = q.rxd ? sfi_pkg::RX_IDLE : sfi_pkg::RX_DATA;
                        end
                    end
                end
                sfi_pkg::RX_DATA: begin
                    if (syncMode ? (clkOutSel ? (tick && !q.sck) : ckRise)
                        : (baseEn && q.rxOs == `SFI_SAMPLE_AT)) begin
                        d.rxShift = {q.rxd, q.rxShift[7:1]};
                        d.rxBit = q.rxBit + 4'h1;
                        if (q.rxBit == `SFI_BITS - 4'h1) begin
                            d.rxSt = sfi_pkg::RX_STOP;
                            d.par = sfiParity({q.rxd, q.rxShift[7:1]});
                        end
                    end
                    if (baseEn && !syncMode) begin
                        d.rxOs = q.rxOs + 4'h1;
                    end
                end
                sfi_pkg::RX_STOP: begin
                    if (syncMode || (baseEn && q.rxOs == `SFI_SAMPLE_AT)) begin
                        rxAcc = 1'b1;
                        d.rxSt = sfi_pkg::RX_IDLE;
                    end else if (baseEn) begin
                        d.rxOs = q.rxOs + 4'h1;
                    end
                end
                default: d.rxSt = sfi_pkg::RX_IDLE;
            endcase
        end
        // Frame end check; hardware set wins over software clear
        if (rxAcc) begin
            if (q.stat[`SFI_ST_RX_FULL_FLAG]) begin
                d.stat[`SFI_ST_OVR] = 1'b1;
            end else begin
                d.rxBuf = q.rxShift;
                d.stat[`SFI_ST_RX_FULL_FLAG] = 1'b1;
            end
            // Error flags set on an overrun frame too
            if (!syncMode && !q.rxd) begin
                d.stat[`SFI_ST_FER] = 1'b1;
            end
            if (!syncMode && q.mode[1] && (q.par ^ q.mode[2]) != q.rxd) begin
                d.stat[`SFI_ST_PER] = 1'b1;
            end
        end

        // Pin handover glitches: one cycle each
        d.txWasSer = txEn;
        d.ckWasSer = clkOutSel && (txEn || rxEn);
        d.txGlitch = q.txWasSer && !txEn && syncMode;
        d.ckGlitch = q.ckWasSer && !(clkOutSel && (txEn || rxEn)) &&
                     !(syncMode && q.ctrl[`SFI_CTRL_CKHI]);

        // Shared request, OR of four enabled causes
        d.irq = (q.ctrl[`SFI_CTRL_TIE] && d.stat[`SFI_ST_TX_EMPTY_FLAG]) ||
                (q.ctrl[`SFI_CTRL_TX_END_IRQ_ENABLE] && d.stat[`SFI_ST_TX_END_FLAG]) ||
                (q.ctrl[`SFI_CTRL_RIE] && d.stat[`SFI_ST_RX_FULL_FLAG]) ||
                (q.ctrl[`SFI_CTRL_RIE] && (d.stat[`SFI_ST_OVR] ||
                 d.stat[`SFI_ST_FER] || d.stat[`SFI_ST_PER]));
        d.stat[1:0] = 2'h0;
    end

    always_ff @(posedge sysClk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.stat <= `SFI_STAT_RST;
            q.baud <= `SFI_BAUD_RST;
            q.txd <= 1'b1;
            q.sck <= 1'b1;
            q.rxSync <= 3'h7;
            q.rxd <= 1'b1;
            q.ckSync <= 3'h7;
            q.ckLast <= 1'b1;
            q.txShift <= 8'hFF;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        avsWaitrequest = (avsRead || avsWrite) && !q.ack;
        avsReaddata = q.rdata;
        irq = q.irq;
        if (txEn) begin
            txdOut = q.txd;
            txdOe = 1'b1;
        end else if (q.txGlitch) begin
            txdOut = 1'b1;
            txdOe = 1'b1;
        end else begin
            txdOut = q.port[`SFI_PORT_DATA];
            txdOe = q.port[`SFI_PORT_DIR];
        end
        sckOut = q.ckGlitch ? 1'b0 : q.sck;
        sckOe = q.ckWasSer || q.ckGlitch;
    end
endmodule : sfi_serial_unit
`default_nettype wire

// ==== sfi_serial_unit_assertions.sv ====
// Checker of bus handshake, pin hand-over and interrupt level
// Assumes binding onto sfi_serial_unit; sees only its ports
`include "sfi_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module sfi_unit_checker (
    // Clock and reset
    input wire logic sysClk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [`SFI_ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [7:0] avsWritedata,
    input wire logic [7:0] avsReaddata,
    input wire logic avsWaitrequest,
    // Serial pins
    input wire logic rxdPin,
    input wire logic txdOut,
    input wire logic txdOe,
    input wire logic sckIn,
    input wire logic sckOut,
    input wire logic sckOe,
    // Shared interrupt
    input wire logic irq
);
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (!nrst);
    // Shadows of written bits; quiet counts cycles since a write
    logic [7:0] ctrlQ;
    logic [7:0] portQ;
    logic syncQ;
    logic txWrQ;
    logic [2:0] quietQ;
    wire logic req = avsRead | avsWrite;
    wire logic wrAcc = avsWrite & ~avsWaitrequest;
    always_ff @(posedge sysClk or negedge nrst) begin
        if (!nrst) begin
            ctrlQ <= 8'h00;
            portQ <= 8'h00;
            syncQ <= 1'b0;
            txWrQ <= 1'b0;
            quietQ <= 3'h0;
        end else begin
            if (wrAcc) begin
                quietQ <= 3'h0;
            end else if (quietQ != 3'h7) begin
                quietQ <= quietQ + 3'h1;
            end
            if (wrAcc && avsAddress == `SFI_OFS_CTRL) ctrlQ <= avsWritedata;
            if (wrAcc && avsAddress == `SFI_OFS_PORT) portQ <= avsWritedata;
            if (wrAcc && avsAddress == `SFI_OFS_MODE) syncQ <= avsWritedata[0];
            if (wrAcc && avsAddress == `SFI_OFS_TXB) txWrQ <= 1'b1;
        end
    end
    wire logic tx_irq_enable = ctrlQ[`SFI_CTRL_TIE] | ctrlQ[`SFI_CTRL_TX_END_IRQ_ENABLE];
    wire logic anyEn = tx_irq_enable | ctrlQ[`SFI_CTRL_RIE];
    wire logic txOn = ctrlQ[`SFI_CTRL_TXEN];
    sequence s_start;
        req && !$past(req);
    endsequence
    sequence s_held;
        req && avsWaitrequest ##1 req;
    endsequence
    property p_waitFirst;
        s_start |-> avsWaitrequest;
    endproperty
    property p_waitSecond;
        s_held |-> !avsWaitrequest;
    endproperty
    property p_unmapped;
        avsRead && !avsWaitrequest && avsAddress == 3'h7 |-> avsReaddata == 8'h00;
    endproperty
    property p_readHold;
        !avsRead ##1 !avsRead |-> $stable(avsReaddata);
    endproperty
    property p_portPin;
        quietQ >= 3'h3 && !txOn |->
            txdOe == portQ[`SFI_PORT_DIR] && txdOut == portQ[`SFI_PORT_DATA];
    endproperty
    property p_markIdle;
        quietQ >= 3'h3 && txOn && !txWrQ && !syncQ |-> txdOe && txdOut;
    endproperty
    property p_irqOff;
        quietQ >= 3'h3 && !anyEn |-> !irq;
    endproperty
    property p_irqInit;
        quietQ >= 3'h3 && tx_irq_enable && !txWrQ |-> irq;
    endproperty
    a_waitFirst: assert property (p_waitFirst)
        else $error("waitrequest low in first request cycle");
    a_waitSecond: assert property (p_waitSecond)
        else $error("more than one wait state");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped index read not zero");
    a_readHold: assert property (p_readHold)
        else $error("read data changed without a read");
    a_portPin: assert property (p_portPin)
        else $error("transmit pin not under port bits");
    a_markIdle: assert property (p_markIdle)
        else $error("idle transmit pin not at mark");
    a_irqOff: assert property (p_irqOff)
        else $error("interrupt with all enables off");
    a_irqInit: assert property (p_irqInit)
        else $error("no request from reset flags");
endmodule : sfi_unit_checker
bind sfi_serial_unit sfi_unit_checker u_sfi_unit_checker (
    .sysClk(sysClk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .rxdPin(rxdPin), .txdOut(txdOut), .txdOe(txdOe), .sckIn(sckIn),
    .sckOut(sckOut), .sckOe(sckOe), .irq(irq));
`default_nettype wire

// ==== sfi_partner.sv ====
// Remote partner: sends frames to the unit, collects what it sends
// Assumes 8 data bits LSB first, one stop bit, BIT_CYC clocks a bit
`timescale 1ns/100ps
`default_nettype none
module sfi_partner #(
    parameter int BIT_CYC = 16
) (
    // Clock
    input wire logic sysClk,
    // Unit transmit pin
    input wire logic txd,
    input wire logic txdOe,
    // Unit receive pin
    output var logic rxd
);
    logic [7:0] seen[$];
    logic [7:0] got;
    // Line idles at mark, as with a pull-up
    initial rxd = 1'b1;
    // Stop of 0 forces a framing fault
    task automatic send(input logic [7:0] d, input logic stop);
        for (int i = 0; i < 10; i++) begin
            @(posedge sysClk);
            rxd <= (i == 0) ? 1'b0 : (i == 9) ? stop : d[i-1];
            repeat (BIT_CYC - 1) @(posedge sysClk);
        end
        @(posedge sysClk);
        rxd <= 1'b1;
        repeat (BIT_CYC) @(posedge sysClk);
    endtask : send
    // Break: line held low
    task automatic hold(input int n);
        @(posedge sysClk);
        rxd <= 1'b0;
        repeat (n) @(posedge sysClk);
        rxd <= 1'b1;
    endtask : hold
    // Samples mid-bit; falls while txdOe is low are ignored
    always begin
        @(negedge txd iff txdOe);
        repeat (BIT_CYC / 2) @(posedge sysClk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge sysClk);
            got[i] = txd;
        end
        seen.push_back(got);
        repeat (BIT_CYC) @(posedge sysClk);
    end
endmodule : sfi_partner
`default_nettype wire

// ==== serial_flag_interrupt_logic_tb.sv ====
// Bench: register traffic, frames both ways, flags and interrupt
// Assumes baud divider 0, so one bit is 16 clocks
`include "sfi_consts.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module serial_flag_interrupt_logic_tb;
    localparam logic [2:0] MD = `SFI_OFS_MODE, CT = `SFI_OFS_CTRL;
    localparam logic [2:0] ST = `SFI_OFS_STAT, TB = `SFI_OFS_TXB;
    localparam logic [2:0] RB = `SFI_OFS_RXB, PT = `SFI_OFS_PORT;
    logic sysClk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdat = 8'h00, q;
    wire logic [7:0] rdat;
    wire logic waitReq, txd, txdOe, sckOut, sckOe, irq, rxd;
    int miscompares = 0, checksDone = 0;
    logic [7:0] enTab [4] = '{8'h80, 8'h04, 8'h40, 8'h00};
    logic irqTab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    always #5 sysClk = ~sysClk;
    sfi_serial_unit u_sfi_serial_unit (.sysClk(sysClk), .nrst(nrst),
        .avsAddress(addr), .avsRead(rd), .avsWrite(wr), .avsWritedata(wdat),
        .avsReaddata(rdat), .avsWaitrequest(waitReq), .rxdPin(rxd),
        .txdOut(txd), .txdOe(txdOe), .sckIn(1'b1), .sckOut(sckOut),
        .sckOe(sckOe), .irq(irq));
    sfi_partner #(.BIT_CYC(16)) u_sfi_partner (.sysClk(sysClk), .txd(txd),
        .txdOe(txdOe), .rxd(rxd));
    // Held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [2:0] a, input logic w,
                       input logic [7:0] d);
        logic busy;
        @(posedge sysClk);
        addr <= a;
        rd <= ~w;
        wr <= w;
        wdat <= d;
        do begin
            @(posedge sysClk);
            busy = waitReq;
            q = rdat;
        end while (busy);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdChk(input logic [2:0] a, input logic [7:0] e,
                         input string n);
        bus(a, 1'b0, 8'h00);
        `CHK(n, e, q)
    endtask : rdChk
    // Ends at a falling edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge sysClk);
        @(negedge sysClk);
    endtask : cyc
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (20000) @(posedge sysClk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge sysClk);
        nrst <= 1'b1;
        rdChk(ST, 8'h84, "status after reset");
        bus(3'h7, 1'b1, 8'hFF);
        rdChk(3'h7, 8'h00, "unmapped read");
        foreach (enTab[i]) begin
            bus(CT, 1'b1, enTab[i]);
            cyc(3);
            `CHK("irq per enable", irqTab[i], irq)
        end
        // Unsent byte overwritten, then line back at mark
        bus(`SFI_OFS_BAUD, 1'b1, 8'h00);
        bus(CT, 1'b1, 8'h20);
        cyc(4);
        bus(TB, 1'b1, 8'h5A);
        cyc(4);
        bus(TB, 1'b1, 8'h11);
        bus(TB, 1'b1, 8'h99);
        rdChk(ST, 8'h00, "empty and end clear");
        cyc(400);
        `CHK("frames", 2, u_sfi_partner.seen.size())
        `CHK("first", 8'h5A, u_sfi_partner.seen[0])
        `CHK("second", 8'h99, u_sfi_partner.seen[1])
        rdChk(ST, 8'h84, "empty and end set");
        `CHK("mark", 1'b1, txd)
        // Receive, double read, overrun
        bus(CT, 1'b1, 8'h70);
        u_sfi_partner.send(8'h3C, 1'b1);
        rdChk(ST, 8'hC4, "full");
        `CHK("irq full", 1'b1, irq)
        rdChk(RB, 8'h3C, "rx byte");
        rdChk(RB, 8'h3C, "second read");
        rdChk(ST, 8'h84, "full clear");
        u_sfi_partner.send(8'h11, 1'b1);
        u_sfi_partner.send(8'h22, 1'b0);
        rdChk(ST, 8'hF4, "overrun");
        rdChk(RB, 8'h11, "kept byte");
        rdChk(ST, 8'hB4, "full clear after overrun");
        `CHK("irq error", 1'b1, irq)
        bus(CT, 1'b1, 8'h60);
        rdChk(ST, 8'hB4, "errors kept");
        bus(ST, 1'b1, 8'h00);
        cyc(3);
        `CHK("irq cleared", 1'b0, irq)
        // Parity and framing faults keep data; break sets framing again
        bus(CT, 1'b1, 8'h70);
        bus(MD, 1'b1, 8'h02);
        u_sfi_partner.send(8'h3C, 1'b1);
        rdChk(ST, 8'hCC, "parity");
        rdChk(RB, 8'h3C, "parity byte");
        bus(ST, 1'b1, 8'h00);
        bus(MD, 1'b1, 8'h00);
        u_sfi_partner.send(8'h55, 1'b0);
        rdChk(ST, 8'hD4, "framing");
        rdChk(RB, 8'h55, "framing byte");
        fork
            u_sfi_partner.hold(400);
            begin
                cyc(40);
                bus(ST, 1'b1, 8'h00);
                cyc(250);
                bus(ST, 1'b0, 8'h00);
                `CHK("framing again", 1'b1, q[`SFI_ST_FER])
            end
        join
        cyc(200);
        // Synchronous mode: error flag blocks transmit start
        bus(MD, 1'b1, 8'h01);
        bus(CT, 1'b1, 8'h20);
        bus(TB, 1'b1, 8'hA5);
        cyc(100);
        bus(ST, 1'b0, 8'h00);
        `CHK("no start", 1'b0, q[`SFI_ST_TX_EMPTY_FLAG])
        bus(ST, 1'b1, 8'h00);
        cyc(100);
        bus(ST, 1'b0, 8'h00);
        `CHK("start", 1'b1, q[`SFI_ST_TX_EMPTY_FLAG])
        // Stop with external clock selected: no clock glitch
        bus(CT, 1'b1, 8'h02);
        cyc(1);
        `CHK("quiet clock pin", 1'b1, sckOut)
        bus(CT, 1'b1, 8'h20);
        // Pin handed to port bits: break, then mark
        bus(PT, 1'b1, 8'h02);
        bus(CT, 1'b1, 8'h00);
        cyc(1);
        `CHK("clock glitch", 1'b0, sckOut)
        `CHK("data glitch", 1'b1, txd)
        cyc(2);
        `CHK("break level", 1'b0, txd)
        `CHK("break drive", 1'b1, txdOe)
        bus(PT, 1'b1, 8'h03);
        cyc(3);
        `CHK("mark level", 1'b1, txd)
        complete_run();
    end
endmodule : serial_flag_interrupt_logic_tb
`default_nettype wire
